// file: src/agu_defines.svh
// Constants for the address generation unit: offsets, codes and reset values.
// Assumes inclusion by the modules of this block only.
`ifndef AGU_DEFINES_SVH
`define AGU_DEFINES_SVH
`define AGU_TABLE_BASE   16'h0040
`define AGU_SHORT_UPPER  7'h7f
`define AGU_SHORT_SPLIT  8'h20
`define AGU_SFR_BASE     16'hff00
`define AGU_OP_PUSH_DE   8'haa
`define AGU_PAIR_AX      2'h0
`define AGU_PAIR_DE      2'h2
`define AGU_PAIR_HL      2'h3
`define AGU_ADDR_RESET   16'h0000
`endif

// file: src/agu_pkg.sv
// Types shared by the address generation unit.
// Assumes the defines header is available on the include path.
package agu_pkg;
  typedef enum logic [3:0] {
    AGU_M_NONE     = 4'h0,
    AGU_M_ABS      = 4'h1,
    AGU_M_TABLE    = 4'h2,
    AGU_M_REG_BR   = 4'h3,
    AGU_M_DIRECT   = 4'h4,
    AGU_M_SHORT    = 4'h5,
    AGU_M_SFR      = 4'h6,
    AGU_M_REG      = 4'h7,
    AGU_M_INDIRECT = 4'h8,
    AGU_M_BASED    = 4'h9,
    AGU_M_STACK    = 4'ha
  } agu_mode_t;

  typedef enum logic [1:0] {
    AGU_S_IDLE = 2'b00,
    AGU_S_LOW  = 2'b01,
    AGU_S_HIGH = 2'b10
  } agu_state_t;

  typedef struct packed {
    logic        valid;
    agu_mode_t   mode;
    logic [7:0]  opcode;
    logic [15:0] absolute_target;
    logic [7:0]  operand;
    logic [2:0]  reg_code;
    logic [1:0]  pair_register_code;
  } agu_req_t;

  typedef struct packed {
    logic [15:0] accumulator_pair;
    logic [15:0] pointer_pair_two;
    logic [15:0] base_pointer_pair;
    logic [15:0] stack_pointer;
  } agu_regs_t;

  typedef struct packed {
    logic        pc_load;
    logic [15:0] program_counter;
    logic        mem_valid;
    logic [15:0] mem_addr;
    logic        reg_valid;
    logic [2:0]  reg_sel;
    logic        reg_pair;
    logic        stack_use;
    logic        push_pointer_pair_two;
  } agu_out_t;
endpackage

// file: src/agu_table_reader.sv
// Fetches a 16-bit vector from the call table one byte at a time.
// Assumes each byte returns one cycle after its request is raised here.
`include "agu_defines.svh"
module agu_table_reader
  import agu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [4:0]  vector_index,
  input  wire logic [7:0]  rd_data,
  output logic             rd_req,
  output logic [15:0]      rd_addr,
  output logic             done,
  output logic [15:0]      target
);
  typedef struct packed {
    agu_state_t  st;
    logic        rd_req;
    logic [15:0] rd_addr;
    logic        done;
    logic [7:0]  low_byte;
  } agu_tr_t;

  agu_tr_t s_q;
  agu_tr_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rd_req = 1'b0;
    unique case (s_q.st)
      AGU_S_IDLE: begin
        if (start) begin
          s_d.rd_addr = 16'(`AGU_TABLE_BASE +
            {10'h000, vector_index, 1'b0});
          s_d.rd_req = 1'b1;
          s_d.st = AGU_S_LOW;
        end
      end
      AGU_S_LOW: begin
        s_d.rd_addr = 16'(s_q.rd_addr + 16'h0001);
        s_d.rd_req = 1'b1;
        s_d.st = AGU_S_HIGH;
      end
      AGU_S_HIGH: begin
        s_d.low_byte = rd_data;
        s_d.done = 1'b1;
        s_d.st = AGU_S_IDLE;
      end
      default: s_d.st = AGU_S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_req = s_q.rd_req;
  assign rd_addr = s_q.rd_addr;
  assign done = s_q.done;
  // High byte is still on the bus in the done cycle
  assign target = {rd_data, s_q.low_byte};

  a_entry_even: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == AGU_S_LOW) |-> (s_q.rd_addr[0] == 1'b0 &&
      s_q.rd_addr[15:6] == 10'h001))
    else $error("table entry address not even inside table");
endmodule

// file: src/agu_core.sv
// Effective address generation for branch targets and operands.
// Assumes decoded fields arrive from the decoder on the core clock.
`include "agu_defines.svh"
module agu_core
  import agu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire agu_req_t    req,
  input  wire agu_regs_t   regs,
  input  wire logic [7:0]  tbl_rd_data,
  output agu_out_t         out,
  output logic             tbl_rd_req,
  output logic [15:0]      tbl_rd_addr,
  output logic             busy
);
  typedef struct packed {
    agu_out_t o;
    logic     busy;
  } agu_st_t;

  agu_st_t s_q;
  agu_st_t s_d;
  logic        tr_done;
  logic [15:0] tr_target;
  logic        tr_start;
  logic        tr_req;
  logic [15:0] tr_addr;
  logic [15:0] tr_addr_q;
  logic        tr_req_q;

  assign tr_start = req.valid && !s_q.busy && req.mode == AGU_M_TABLE;

  agu_table_reader u_tr (
    .clk          (clk),
    .rst          (rst),
    .start        (tr_start),
    .vector_index (req.operand[5:1]),
    .rd_data      (tbl_rd_data),
    .rd_req       (tr_req),
    .rd_addr      (tr_addr),
    .done         (tr_done),
    .target       (tr_target)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      tr_req_q <= 1'b0;
      tr_addr_q <= `AGU_ADDR_RESET;
    end else begin
      tr_req_q <= tr_req;
      tr_addr_q <= tr_addr;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.o.pc_load = 1'b0;
    s_d.o.mem_valid = 1'b0;
    s_d.o.reg_valid = 1'b0;
    s_d.o.stack_use = 1'b0;
    s_d.o.push_pointer_pair_two = 1'b0;
    if (tr_done) begin
      s_d.o.pc_load = 1'b1;
      s_d.o.program_counter = tr_target;
      s_d.busy = 1'b0;
    end else if (req.valid && !s_q.busy) begin
      unique case (req.mode)
        AGU_M_NONE: begin
        end
        AGU_M_ABS: begin
          s_d.o.pc_load = 1'b1;
          s_d.o.program_counter = req.absolute_target;
        end
        AGU_M_TABLE: begin
          s_d.busy = 1'b1;
        end
        AGU_M_REG_BR: begin
          s_d.o.pc_load = 1'b1;
          s_d.o.program_counter = regs.accumulator_pair;
        end
        AGU_M_DIRECT: begin
          s_d.o.mem_valid = 1'b1;
          s_d.o.mem_addr = req.absolute_target;
        end
        AGU_M_SHORT: begin
          s_d.o.mem_valid = 1'b1;
          s_d.o.mem_addr = {`AGU_SHORT_UPPER,
            (req.operand < `AGU_SHORT_SPLIT), req.operand};
        end
        AGU_M_SFR: begin
          s_d.o.mem_valid = 1'b1;
          s_d.o.mem_addr = `AGU_SFR_BASE | {8'h00, req.operand};
        end
        AGU_M_REG: begin
          s_d.o.reg_valid = 1'b1;
          s_d.o.reg_pair = 1'b0;
          s_d.o.reg_sel = req.reg_code;
        end
        AGU_M_INDIRECT: begin
          s_d.o.mem_valid = 1'b1;
          s_d.o.mem_addr = (req.pair_register_code == `AGU_PAIR_DE) ?
            regs.pointer_pair_two : regs.base_pointer_pair;
        end
        AGU_M_BASED: begin
          s_d.o.mem_valid = 1'b1;
          s_d.o.mem_addr = 16'(regs.base_pointer_pair +
            {8'h00, req.operand});
        end
        AGU_M_STACK: begin
          s_d.o.mem_valid = 1'b1;
          s_d.o.stack_use = 1'b1;
          s_d.o.mem_addr = regs.stack_pointer;
        end
        default: begin
        end
      endcase
      if (req.mode == AGU_M_REG && req.opcode != `AGU_OP_PUSH_DE &&
          req.reg_code[2] == 1'b0 && req.pair_register_code != 2'h0) begin
        s_d.o.reg_pair = 1'b0;
      end
      if (req.opcode == `AGU_OP_PUSH_DE) begin
        s_d.o.push_pointer_pair_two = 1'b1;
        s_d.o.mem_valid = 1'b1;
        s_d.o.stack_use = 1'b1;
        s_d.o.mem_addr = regs.stack_pointer;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out = s_q.o;
  assign busy = s_q.busy;
  assign tbl_rd_req = tr_req_q;
  assign tbl_rd_addr = tr_addr_q;

  a_abs_target: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_ABS)
    |=> (out.pc_load && out.program_counter == $past(req.absolute_target)))
    else $error("absolute target not loaded");

  a_abs_pulse: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_ABS
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (!out.mem_valid && !out.reg_valid))
    else $error("absolute branch raised an operand strobe");

  a_table_done: assert property (@(posedge clk) disable iff (rst)
    tr_start |-> ##[3:4] out.pc_load)
    else $error("table call did not load counter");

  a_table_busy: assert property (@(posedge clk) disable iff (rst)
    tr_start |=> busy)
    else $error("table call did not raise busy");

  a_busy_refuse: assert property (@(posedge clk) disable iff (rst)
    (busy && !tr_done)
    |=> (!out.pc_load && !out.mem_valid && !out.reg_valid))
    else $error("request taken during table call");

  a_busy_clear: assert property (@(posedge clk) disable iff (rst)
    tr_done |=> (!busy && out.pc_load))
    else $error("table call did not finish");

  a_table_quiet: assert property (@(posedge clk) disable iff (rst)
    !busy |-> !tbl_rd_req)
    else $error("table read outside table call");

  a_table_index: assert property (@(posedge clk) disable iff (rst)
    tr_start |-> ##2 (tbl_rd_addr[5:1] == $past(req.operand[5:1], 2)))
    else $error("table index not taken from bits one to five");

  a_table_first: assert property (@(posedge clk) disable iff (rst)
    tr_start |-> ##2 (tbl_rd_req && tbl_rd_addr[0] == 1'b0
      && tbl_rd_addr[15:6] == 10'h001))
    else $error("low byte not read at even table address");

  a_table_second: assert property (@(posedge clk) disable iff (rst)
    tr_start |-> ##3 (tbl_rd_req && tbl_rd_addr[0] == 1'b1
      && tbl_rd_addr[15:6] == 10'h001))
    else $error("high byte not read at odd table address");

  a_table_order: assert property (@(posedge clk) disable iff (rst)
    tr_start |-> ##3 (tbl_rd_addr == 16'($past(tbl_rd_addr) + 16'h0001)))
    else $error("high byte not read after low byte");

  a_table_load: assert property (@(posedge clk) disable iff (rst)
    tr_done |-> (tbl_rd_req && tbl_rd_addr[0])
    ##1 (out.program_counter[15:8] == $past(tbl_rd_data)))
    else $error("high byte of vector not loaded");

  a_reg_branch: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_REG_BR
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.program_counter == $past(regs.accumulator_pair)))
    else $error("accumulator pair not loaded");

  a_reg_pc_pulse: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_REG_BR
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.pc_load && !out.mem_valid))
    else $error("register branch did not load counter");

  a_direct_addr: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_DIRECT
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.mem_valid && out.mem_addr == $past(req.absolute_target)))
    else $error("direct address altered");

  a_short_window: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_SHORT
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.mem_addr >= 16'hfe20 && out.mem_addr <= 16'hff1f &&
         out.mem_addr[7:0] == $past(req.operand)))
    else $error("short direct outside window");

  a_short_upper: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_SHORT
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.mem_addr[15:9] == 7'h7f))
    else $error("short direct upper bits not all ones");

  a_short_ram: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_SHORT
     && req.opcode != `AGU_OP_PUSH_DE && req.operand >= 8'h20)
    |=> (out.mem_addr[15:8] == 8'hfe))
    else $error("short direct missed high-speed RAM");

  a_short_sfr: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_SHORT
     && req.opcode != `AGU_OP_PUSH_DE && req.operand < 8'h20)
    |=> (out.mem_addr[15:5] == 11'h7f8))
    else $error("short direct missed register area");

  a_sfr_addr: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_SFR
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.mem_addr == {8'hff, $past(req.operand)}))
    else $error("special register address wrong");

  a_sfr_valid: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_SFR
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.mem_valid && !out.stack_use && out.mem_addr[15:8] == 8'hff))
    else $error("special register access not strobed");

  a_reg_select: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_REG
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.reg_valid && out.reg_sel == $past(req.reg_code)))
    else $error("register select wrong");

  a_reg_no_mem: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_REG
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (!out.mem_valid && !out.pc_load && !out.reg_pair))
    else $error("register operand touched memory");

  a_indirect_pair: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_INDIRECT
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.mem_addr == ($past(req.pair_register_code) == 2'h2 ?
         $past(regs.pointer_pair_two) : $past(regs.base_pointer_pair))))
    else $error("indirect pair wrong");

  a_indirect_valid: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_INDIRECT
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.mem_valid && !out.stack_use))
    else $error("indirect access not strobed");

  a_based_sum: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_BASED
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.mem_addr == 16'($past(regs.base_pointer_pair) +
         {8'h00, $past(req.operand)})))
    else $error("based address wrong");

  a_based_valid: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_BASED
     && req.opcode != `AGU_OP_PUSH_DE)
    |=> (out.mem_valid && !out.pc_load && !out.stack_use))
    else $error("based access not strobed");

  a_stack_use: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.mode == AGU_M_STACK)
    |=> (out.stack_use && out.mem_addr == $past(regs.stack_pointer)))
    else $error("stack pointer not used");

  a_stack_pulse: assert property (@(posedge clk) disable iff (rst)
    out.stack_use |-> out.mem_valid)
    else $error("stack access without memory strobe");

  a_push_de: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.opcode == 8'haa)
    |=> (out.push_pointer_pair_two && out.stack_use))
    else $error("push opcode not recognised");

  a_push_addr: assert property (@(posedge clk) disable iff (rst)
    (req.valid && !s_q.busy && !tr_done && req.opcode == `AGU_OP_PUSH_DE)
    |=> (out.mem_valid && out.mem_addr == $past(regs.stack_pointer)))
    else $error("push did not address the stack");

  a_no_push: assert property (@(posedge clk) disable iff (rst)
    !(req.valid && req.opcode == `AGU_OP_PUSH_DE) |=> !out.push_pointer_pair_two)
    else $error("push flagged without push opcode");
endmodule

// file: tb/agu_mem_model.sv
// Memory model answering table byte reads of the address unit.
// Assumes the unit holds request and address for a whole cycle.
module agu_mem_model (
  input  wire logic        clk,
  input  wire logic        tbl_rd_req,
  input  wire logic [15:0] tbl_rd_addr,
  output logic      [7:0]  tbl_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_q = 8'h00;
  // Byte is a fixed pattern of its address; idle bus toggles
  always_comb begin
    if (tbl_rd_req) begin
      tbl_rd_data = tbl_rd_addr[7:0] ^ 8'h5a;
    end else begin
      tbl_rd_data = ~last_q;
    end
  end
  always_ff @(posedge clk) begin
    last_q <= tbl_rd_data;
  end
endmodule

// file: tb/address_generation_unit_tb.sv
// Self-checking bench for the address generation unit.
// Assumes the memory model answers table reads.
module address_generation_unit_tb
  import agu_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst;
  agu_req_t    req;
  agu_regs_t   regs;
  logic [7:0]  tbl_rd_data;
  agu_out_t    out;
  logic        tbl_rd_req;
  logic [15:0] tbl_rd_addr;
  logic        busy;
  int          err_total = 0;
  int          num_checks = 0;

  agu_core i_agu_core (.clk(clk), .rst(rst), .req(req), .regs(regs),
    .tbl_rd_data(tbl_rd_data), .out(out), .tbl_rd_req(tbl_rd_req),
    .tbl_rd_addr(tbl_rd_addr), .busy(busy));
  agu_mem_model i_agu_mem_model (.clk(clk), .tbl_rd_req(tbl_rd_req),
    .tbl_rd_addr(tbl_rd_addr), .tbl_rd_data(tbl_rd_data));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One request taken at the next edge; returns in the answer cycle
  task automatic issue(input agu_mode_t m, input logic [15:0] t,
                       input logic [7:0] o, input logic [7:0] opc);
    @(posedge clk);
    #1;
    req = '{1'b1, m, opc, t, o, o[2:0], o[1:0]};
    @(posedge clk);
    #1;
    req.valid = 1'b0;
  endtask

  task automatic t_addr(input agu_mode_t m, input logic [15:0] t,
                        input logic [7:0] o, input logic [15:0] e);
    issue(m, t, o, 8'h00);
    chk("mem_valid", 16'h1, {15'h0, out.mem_valid});
    chk("mem_addr", e, out.mem_addr);
  endtask

  task automatic t_branch();
    issue(AGU_M_ABS, 16'hbeef, 8'h00, 8'h00);
    chk("pc_load", 16'h1, {15'h0, out.pc_load});
    chk("pc_abs", 16'hbeef, out.program_counter);
    issue(AGU_M_REG_BR, 16'h0000, 8'h00, 8'h00);
    chk("pc_reg", regs.accumulator_pair, out.program_counter);
    $display("test branch done");
  endtask

  task automatic t_operand();
    t_addr(AGU_M_DIRECT, 16'h1234, 8'h00, 16'h1234);
    t_addr(AGU_M_SHORT, 16'h0000, 8'h00, 16'hff00);
    t_addr(AGU_M_SHORT, 16'h0000, 8'h1f, 16'hff1f);
    t_addr(AGU_M_SHORT, 16'h0000, 8'h20, 16'hfe20);
    t_addr(AGU_M_SHORT, 16'h0000, 8'hff, 16'hfeff);
    t_addr(AGU_M_SFR, 16'h0000, 8'h00, 16'hff00);
    t_addr(AGU_M_SFR, 16'h0000, 8'hff, 16'hffff);
    t_addr(AGU_M_INDIRECT, 16'h0000, 8'h02, 16'h3c4d);
    t_addr(AGU_M_INDIRECT, 16'h0000, 8'h03, 16'hfff8);
    t_addr(AGU_M_BASED, 16'h0000, 8'h10, 16'h0008);
    t_addr(AGU_M_BASED, 16'h0000, 8'hff, 16'h00f7);
    $display("test operand done");
  endtask

  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      issue(AGU_M_REG, 16'h0000, 8'(i), 8'h00);
      chk("reg_valid", 16'h1, {15'h0, out.reg_valid});
      chk("reg_sel", 16'(i), {13'h0, out.reg_sel});
      chk("reg_pair", 16'h0, {15'h0, out.reg_pair});
    end
    $display("test regs done");
  endtask

  task automatic t_stack();
    issue(AGU_M_STACK, 16'h0000, 8'h00, 8'h00);
    chk("stack_use", 16'h1, {15'h0, out.stack_use});
    chk("stack_addr", regs.stack_pointer, out.mem_addr);
    issue(AGU_M_DIRECT, 16'h1234, 8'h00, 8'haa);
    chk("push", 16'h1, {15'h0, out.push_pointer_pair_two});
    chk("push_use", 16'h1, {15'h0, out.stack_use});
    chk("push_addr", regs.stack_pointer, out.mem_addr);
    $display("test stack done");
  endtask

  // Table call with a refused branch presented while busy
  task automatic t_table(input logic [4:0] idx);
    logic [15:0] base;
    int k;
    base = 16'h0040 + {10'h0, idx, 1'b0};
    @(posedge clk);
    #1;
    req = '{1'b1, AGU_M_TABLE, 8'h00, 16'h0000, {2'b00, idx, 1'b0}, 3'h0,
           2'h0};
    @(posedge clk);
    #1;
    req = '{1'b1, AGU_M_ABS, 8'h00, 16'h1111, 8'h00, 3'h0, 2'h0};
    k = 1;
    while (k < 10 && out.pc_load !== 1'b1) begin
      if (k == 2) begin
        chk("rd_req_lo", 16'h1, {15'h0, tbl_rd_req});
        chk("rd_addr_lo", base, tbl_rd_addr);
      end
      if (k == 3) begin
        chk("rd_addr_hi", base + 16'h1, tbl_rd_addr);
      end
      @(posedge clk);
      #1;
      req.valid = 1'b0;
      k++;
    end
    chk("tbl_cycles", 16'h4, 16'(k));
    chk("pc_tbl", {(base[7:0] + 8'h1) ^ 8'h5a, base[7:0] ^ 8'h5a},
        out.program_counter);
    chk("busy_end", 16'h0, {15'h0, busy});
    $display("test table %0d done", idx);
  endtask

  initial begin
    rst = 1'b1;
    req = '0;
    regs = '{16'h1a2b, 16'h3c4d, 16'hfff8, 16'hfe80};
    repeat (8) @(posedge clk);
    #1;
    chk("out_rst", 16'h0, {14'h0, busy, |out});
    rst = 1'b0;
    t_branch();
    t_operand();
    t_regs();
    t_stack();
    t_table(5'h00);
    t_table(5'h1f);
    t_branch();
    complete_run();
  end

  initial begin
    #50000;
    err_total++;
    complete_run();
  end
endmodule
